// File: core/low_power_mode_control.sv
/*
 * Low-power mode controller: mode entry on idle, clock gating, wake decode.
 * Assumes the core clock keeps running; pin wake requests also raise a
 * registered restart request for the real oscillator/clock gates.
 * The software interrupt input is never read, since the CPU clock is off in idle.
 */
`timescale 1ns/100ps
module low_power_mode_control
   import lpm_pkg::*;
(
   input  wire logic       core_clk,          // Core clock, 200 MHz.
   input  wire logic       rst,               // Synchronous reset, active high.
   input  wire logic       idle_exec,         // Idle instruction executes, one-cycle pulse.
   input  wire logic [1:0] low_power_select,  // Mode select from clock_control_reg0.
   input  wire logic       reset_pin_n,       // External reset pin, active low, async.
   input  wire logic       wdt_reset,         // Watchdog timeout reset, same clock.
   input  wire logic       nmi_pin,           // Nonmaskable interrupt pin, async.
   input  wire logic       ext_pin_interrupt, // External interrupt pin, async.
   input  wire logic       ext_int_mask,      // External interrupt enabled when high.
   input  wire logic       rti_irq,           // Real-time interrupt, same clock.
   input  wire logic       periph_irq,        // Unmasked clocked peripheral interrupt.
   input  wire logic       periph_wake_irq,   // Unmasked clockless peripheral wake.
   input  wire logic       sw_irq,            // Software interrupt, never wakes.
   output logic            cpu_clk_en,        // CPU clock domain enable.
   output logic            sys_clk_en,        // System clock domain enable.
   output logic            pll_en,            // PLL power enable.
   output logic            osc_en,            // Oscillator power enable.
   output logic            wdt_clk_en,        // Watchdog clock enable.
   output logic            cpu_halted,        // CPU held in idle.
   output logic            wake_restart,      // Clock restart request, registered.
   output logic [1:0]      active_mode        // Latched mode.
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Each pin passes two flops, so a pin event reaches the state machine two
   // cycles late; the stopped oscillator itself is restarted outside this block.
   logic reset_pin_low;
   logic nmi_s;
   logic xint_s;

   lpm_sync2 u_sync_rst (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (~reset_pin_n),
      .sync_out (reset_pin_low)
   );

   lpm_sync2 u_sync_nmi (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (nmi_pin),
      .sync_out (nmi_s)
   );

   lpm_sync2 u_sync_xint (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (ext_pin_interrupt),
      .sync_out (xint_s)
   );

   // ----------------------------------------------------------------------
   // Wake decode
   // ----------------------------------------------------------------------
   logic pin_wake;
   logic full_exit;
   logic clk_wake_only;
   logic in_low_power;

   lpm_state_t state;
   lpm_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [1:0]       next_active_mode;
   logic             next_cpu_halted;
   logic             next_wake_restart;
   logic             next_cpu_clk_en;
   logic             next_sys_clk_en;
   logic             next_pll_en;
   logic             next_osc_en;
   logic             next_wdt_clk_en;

   assign in_low_power = (state == ST_LIGHT) || (state == ST_DEEP) ||
                         (state == ST_STANDBY) || (state == ST_HALT);

   // Software interrupts are ignored while the CPU clock is off.
   always_comb begin
      pin_wake      = nmi_s || (xint_s && ext_int_mask);
      full_exit     = 1'b0;
      clk_wake_only = 1'b0;
      case (state)
         ST_LIGHT: begin
            // Peripheral clocks still run here, so any unmasked source wakes.
            full_exit = pin_wake || wdt_reset || rti_irq ||
                        periph_irq || periph_wake_irq;
         end
         ST_DEEP, ST_STANDBY: begin
            // Only sources that need no system clock can end these modes.
            full_exit = pin_wake || wdt_reset || rti_irq ||
                        periph_wake_irq;
         end
         ST_HALT: begin
            // Watchdog and real-time sources have no clock in halt.
            full_exit = pin_wake || periph_wake_irq;
         end
         default: begin
            full_exit = 1'b0;
         end
      endcase
      clk_wake_only = in_low_power && !full_exit && xint_s && !ext_int_mask;
   end

   // ----------------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_cnt          = cnt;
      next_active_mode  = active_mode;
      next_cpu_halted   = cpu_halted;
      next_wake_restart = 1'b0;
      // The reset pin outranks every other source and returns straight to run.
      if (reset_pin_low) begin
         next_state      = ST_RUN;
         next_cpu_halted = 1'b0;
         next_cnt        = '0;
      end else begin
         case (state)
            ST_RUN: begin
               next_cpu_halted = 1'b0;
               // The mode is latched here and held until the next idle entry.
               if (idle_exec) begin
                  next_active_mode = low_power_select;
                  next_cpu_halted  = 1'b1;
                  case (low_power_select)
                     SEL_LIGHT_IDLE: next_state = ST_LIGHT;
                     SEL_DEEP_IDLE:  next_state = ST_DEEP;
                     SEL_STANDBY:    next_state = ST_STANDBY;
                     default:        next_state = ST_HALT;
                  endcase
               end
            end
            ST_LIGHT, ST_DEEP: begin
               // Watchdog reset and wakes share the same return path.
               if (full_exit) begin
                  next_state        = ST_RUN;
                  next_cpu_halted   = 1'b0;
                  next_wake_restart = 1'b1;
               end else if (clk_wake_only && state == ST_DEEP) begin
                  next_state        = ST_LIGHT;
                  next_wake_restart = 1'b1;
               end
            end
            ST_STANDBY: begin
               // A masked pin wake keeps the CPU halted through the lock wait.
               if (full_exit || clk_wake_only) begin
                  next_state        = ST_PLL_WAIT;
                  next_cnt          = CNT_W'(PLL_LOCK_CYCLES);
                  next_wake_restart = 1'b1;
                  next_cpu_halted   = !full_exit;
               end
            end
            ST_HALT: begin
               if (full_exit || clk_wake_only) begin
                  next_state        = ST_OSC_WAIT;
                  next_cnt          = CNT_W'(OSC_START_CYCLES);
                  next_wake_restart = 1'b1;
                  next_cpu_halted   = !full_exit;
               end
            end
            ST_OSC_WAIT: begin
               // The oscillator must settle before the lock count starts.
               if (cnt <= CNT_W'(1)) begin
                  next_state = ST_PLL_WAIT;
                  next_cnt   = CNT_W'(PLL_LOCK_CYCLES);
               end else begin
                  next_cnt = cnt - CNT_W'(1);
               end
            end
            ST_PLL_WAIT: begin
               if (cnt <= CNT_W'(1)) begin
                  next_cnt = '0;
                  // A masked-pin wake parks in light idle with clocks back.
                  next_state = cpu_halted ? ST_LIGHT : ST_RUN;
               end else begin
                  next_cnt = cnt - CNT_W'(1);
               end
            end
            default: begin
               // An illegal state falls back to run.
               next_state      = ST_RUN;
               next_cpu_halted = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Clock gating per state
   // ----------------------------------------------------------------------
   // Every state spells out all five enables, so that no state can inherit
   // a running clock by accident. The CPU clock runs only in run.
   always_comb begin
      case (next_state)
         ST_RUN: begin
            next_cpu_clk_en = 1'b1;
            next_sys_clk_en = 1'b1;
            next_pll_en     = 1'b1;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b1;
         end
         ST_LIGHT: begin
            next_cpu_clk_en = 1'b0;
            next_sys_clk_en = 1'b1;
            next_pll_en     = 1'b1;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b1;
         end
         ST_DEEP: begin
            next_cpu_clk_en = 1'b0;
            next_sys_clk_en = 1'b0;
            next_pll_en     = 1'b1;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b1;
         end
         ST_STANDBY: begin
            next_cpu_clk_en = 1'b0;
            next_sys_clk_en = 1'b0;
            next_pll_en     = 1'b0;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b0;
         end
         ST_HALT: begin
            next_cpu_clk_en = 1'b0;
            next_sys_clk_en = 1'b0;
            next_pll_en     = 1'b0;
            next_osc_en     = 1'b0;
            next_wdt_clk_en = 1'b0;
         end
         ST_OSC_WAIT: begin
            next_cpu_clk_en = 1'b0;
            next_sys_clk_en = 1'b0;
            next_pll_en     = 1'b1;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b0;
         end
         ST_PLL_WAIT: begin
            next_cpu_clk_en = 1'b0;
            next_sys_clk_en = 1'b0;
            next_pll_en     = 1'b1;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b0;
         end
         default: begin
            next_cpu_clk_en = 1'b1;
            next_sys_clk_en = 1'b1;
            next_pll_en     = 1'b1;
            next_osc_en     = 1'b1;
            next_wdt_clk_en = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Mode state registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state        <= ST_RUN;
         cnt          <= '0;
         active_mode  <= SEL_LIGHT_IDLE;
         cpu_halted   <= 1'b0;
         wake_restart <= 1'b0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         active_mode  <= next_active_mode;
         cpu_halted   <= next_cpu_halted;
         wake_restart <= next_wake_restart;
      end
   end

   // ----------------------------------------------------------------------
   // Clock enable registers
   // ----------------------------------------------------------------------
   // All enables come out of reset on, so the device starts in run.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_clk_en <= 1'b1;
         sys_clk_en <= 1'b1;
         pll_en     <= 1'b1;
         osc_en     <= 1'b1;
         wdt_clk_en <= 1'b1;
      end else begin
         cpu_clk_en <= next_cpu_clk_en;
         sys_clk_en <= next_sys_clk_en;
         pll_en     <= next_pll_en;
         osc_en     <= next_osc_en;
         wdt_clk_en <= next_wdt_clk_en;
      end
   end

endmodule

// File: core/lpm_pkg.sv
/*
 * Constants and types for the low-power mode controller.
 * Assumes a single 200 MHz core clock and a synchronous active-high reset.
 */
//
// Behaviour
// - Enter low power only on idle instruction.
// - Select 00 light, 01 deep, 10 standby, 11 halt.
// - CPU clock stopped; software interrupts never wake.
// - Reset pin ends every low-power mode.
// - Watchdog reset ends all modes except halt.
// - NMI or unmasked pin interrupt ends every mode.
// - Pin interrupts restart clocks combinationally; here wake_restart is registered after a two-flop sync.
// - Masked pin interrupt restarts clocks, CPU stays idle.
// - Clockless peripheral wake restarts stopped clocks.
// - Halt ends by reset, pins, clockless peripherals.
// - Light idle ends on any unmasked peripheral.
// - Deep idle, standby end on clockless peripheral.
// - Real-time interrupt wakes all except halt.
// - Clock gating deepens per mode.
// - Wait oscillator start and PLL lock.
package lpm_pkg;

   // ----------------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] SEL_LIGHT_IDLE = 2'h0;
   localparam logic [1:0] SEL_DEEP_IDLE  = 2'h1;
   localparam logic [1:0] SEL_STANDBY    = 2'h2;
   localparam logic [1:0] SEL_HALT       = 2'h3;

   // ----------------------------------------------------------------------
   // Start-up timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int OSC_START_US     = 10;
   localparam int PLL_LOCK_US      = 5;
   localparam int OSC_START_CYCLES = (OSC_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PLL_LOCK_CYCLES  = (PLL_LOCK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W            = 20;

   // ----------------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_RUN      = 7'h01,
      ST_LIGHT    = 7'h02,
      ST_DEEP     = 7'h04,
      ST_STANDBY  = 7'h08,
      ST_HALT     = 7'h10,
      ST_OSC_WAIT = 7'h20,
      ST_PLL_WAIT = 7'h40
   } lpm_state_t;

endpackage

// File: core/lpm_sync2.sv
/*
 * Two-flop synchroniser for one level.
 * Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/100ps
module lpm_sync2 (
   input  wire logic core_clk, // Core clock.
   input  wire logic rst,      // Synchronous reset.
   input  wire logic async_in, // Asynchronous level.
   output logic      sync_out  // Synchronised level.
);
   logic stage1;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// File: verif/lpm_assertions.sv
/*
 * Concurrent checks on the low-power mode controller ports.
 * Assumes the bench holds pin inputs for several cycles at a time.
 */
`timescale 1ns/100ps
module lpm_checker
   import lpm_pkg::*;
(
   input wire logic       core_clk,          // Clock.
   input wire logic       rst,               // Reset.
   input wire logic       idle_exec,         // Idle pulse.
   input wire logic [1:0] low_power_select,  // Mode select.
   input wire logic       reset_pin_n,       // Reset pin.
   input wire logic       nmi_pin,           // NMI pin.
   input wire logic       ext_pin_interrupt, // Pin interrupt.
   input wire logic       periph_wake_irq,   // Clockless wake.
   input wire logic       cpu_clk_en,        // CPU clock.
   input wire logic       sys_clk_en,        // System clock.
   input wire logic       pll_en,            // PLL.
   input wire logic       osc_en,            // Oscillator.
   input wire logic       wdt_clk_en,        // Watchdog clock.
   input wire logic       cpu_halted,        // CPU idle.
   input wire logic       wake_restart,      // Restart pulse.
   input wire logic [1:0] active_mode        // Latched mode.
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_entry;
      idle_exec && cpu_clk_en && !cpu_halted && $past(reset_pin_n, 2)
         |=> cpu_halted && !cpu_clk_en && active_mode == $past(low_power_select);
   endproperty
   a_entry: assert property (p_entry) else $error("idle entry wrong");
   property p_cpu_off;
      cpu_halted |-> !cpu_clk_en;
   endproperty
   a_cpu_off: assert property (p_cpu_off) else $error("cpu clock on in idle");
   property p_deep_gate;
      $rose(cpu_halted) && active_mode == SEL_DEEP_IDLE |-> !sys_clk_en && pll_en && osc_en && wdt_clk_en;
   endproperty
   a_deep_gate: assert property (p_deep_gate) else $error("deep gating wrong");
   property p_halt_gate;
      $rose(cpu_halted) && active_mode == SEL_HALT |-> !(sys_clk_en || pll_en || osc_en || wdt_clk_en);
   endproperty
   a_halt_gate: assert property (p_halt_gate) else $error("halt gating wrong");
   property p_halt_holds;
      (!osc_en && reset_pin_n && !nmi_pin && !ext_pin_interrupt && !periph_wake_irq) [*3] |=> !osc_en;
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("halt left wrongly");
   property p_pin_wake;
      $rose(nmi_pin) && cpu_halted && (wdt_clk_en || !pll_en) |-> ##[1:4] wake_restart;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake late");
   property p_reset_pin;
      (!reset_pin_n) [*4] |=> !cpu_halted && cpu_clk_en;
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
   property p_wait_lock;
      $rose(osc_en) && !cpu_clk_en |-> !cpu_clk_en [*8];
   endproperty
   a_wait_lock: assert property (p_wait_lock) else $error("no start-up wait");
endmodule

bind low_power_mode_control lpm_checker lpm_checker_inst (
   .core_clk(core_clk), .rst(rst), .idle_exec(idle_exec), .low_power_select(low_power_select),
   .reset_pin_n(reset_pin_n), .nmi_pin(nmi_pin), .ext_pin_interrupt(ext_pin_interrupt),
   .periph_wake_irq(periph_wake_irq), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .pll_en(pll_en),
   .osc_en(osc_en), .wdt_clk_en(wdt_clk_en), .cpu_halted(cpu_halted), .wake_restart(wake_restart),
   .active_mode(active_mode));

// File: verif/lpm_cpu_model.sv
/*
 * CPU side model: issues the idle instruction and sets the pin enable.
 * Assumes the bench requests one idle at a time.
 */
`timescale 1ns/100ps
module lpm_cpu_model (
   input  wire logic       core_clk,         // Clock.
   input  wire logic       rst,              // Reset.
   input  wire logic       idle_req,         // Bench asks for idle.
   input  wire logic [1:0] sel_req,          // Wanted mode.
   input  wire logic       mask_req,         // Wanted pin enable.
   output logic            idle_exec,        // Idle pulse.
   output logic [1:0]      low_power_select, // Mode select.
   output logic            ext_int_mask      // Pin enable.
);
   always_ff @(posedge core_clk) begin
      idle_exec        <= idle_req & ~rst & ~idle_exec;
      low_power_select <= sel_req;
      ext_int_mask     <= mask_req;
   end
endmodule

// File: verif/tb_top.sv
/*
 * Self-checking bench for the low-power mode controller.
 * Assumes the CPU model and checker files are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
   import lpm_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst, reset_pin_n, idle_req, mask_req;
   logic [1:0] sel_req, low_power_select, active_mode;
   logic [6:0] stim;
   logic       idle_exec, ext_int_mask, cpu_clk_en, sys_clk_en, pll_en, osc_en, wdt_clk_en;
   logic       cpu_halted, wake_restart;
   int         failures = 0;
   int         tests_run = 0;
   int         cycles = 0;
   wire  [7:0] st = {cpu_halted, cpu_clk_en, sys_clk_en, pll_en, osc_en, wdt_clk_en, active_mode};

   always #2.5 core_clk = ~core_clk;

   lpm_cpu_model lpm_cpu_model_inst (.core_clk(core_clk), .rst(rst), .idle_req(idle_req), .sel_req(sel_req),
      .mask_req(mask_req), .idle_exec(idle_exec), .low_power_select(low_power_select), .ext_int_mask(ext_int_mask));
   low_power_mode_control low_power_mode_control_inst (.core_clk(core_clk), .rst(rst), .idle_exec(idle_exec),
      .low_power_select(low_power_select), .reset_pin_n(reset_pin_n), .wdt_reset(stim[0]), .nmi_pin(stim[1]),
      .ext_pin_interrupt(stim[2]), .ext_int_mask(ext_int_mask), .rti_irq(stim[3]), .periph_irq(stim[4]),
      .periph_wake_irq(stim[5]), .sw_irq(stim[6]), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
      .pll_en(pll_en), .osc_en(osc_en), .wdt_clk_en(wdt_clk_en), .cpu_halted(cpu_halted),
      .wake_restart(wake_restart), .active_mode(active_mode));

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] idle_st(input logic [1:0] sel);
      logic [4:0] g;
      g = (sel == SEL_LIGHT_IDLE) ? 5'h0f : (sel == SEL_DEEP_IDLE) ? 5'h07 : (sel == SEL_STANDBY) ? 5'h02 : 5'h00;
      return {1'b1, g, sel};
   endfunction

   task automatic enter(input logic [1:0] sel);
      @(posedge core_clk) begin
         sel_req  <= sel;
         idle_req <= 1'b1;
      end
      @(posedge core_clk) idle_req <= 1'b0;
      @(posedge core_clk) #1;
   endtask

   task automatic hit(input logic [6:0] v);
      @(posedge core_clk) stim <= v;
      repeat (4) @(posedge core_clk);
      stim <= 7'h00;
   endtask

   task automatic wait_run(input int limit, output int n);
      n = 0;
      #1;
      while (n < limit && cpu_clk_en !== 1'b1) begin
         @(posedge core_clk) #1;
         n++;
      end
   endtask

   task automatic t_modes();
      int n;
      int lo;
      for (int s = 0; s < 4; s++) begin
         enter(2'(s));
         check(st, idle_st(2'(s)));
         hit(7'h02);
         wait_run(3200, n);
         check(st & 8'hfc, 8'h7c);
         lo = (s == 3) ? OSC_START_CYCLES + PLL_LOCK_CYCLES - 10 : (s == 2) ? PLL_LOCK_CYCLES - 10 : 0;
         check(8'(n >= lo), 8'h01);
      end
      $display("modes test done");
   endtask

   task automatic try_wake(input logic [1:0] sel, input logic [6:0] bad, input logic [6:0] good, input int lim);
      int n;
      enter(sel);
      hit(bad);
      repeat (3) @(posedge core_clk);
      #1;
      check(st, idle_st(sel));
      hit(good);
      wait_run(lim, n);
      check(st & 8'hfc, 8'h7c);
      $display("wake test done");
   endtask

   task automatic t_reset_pin();
      int n;
      enter(SEL_HALT);
      enter(SEL_LIGHT_IDLE);
      check(st, idle_st(SEL_HALT));
      @(posedge core_clk) reset_pin_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      reset_pin_n <= 1'b1;
      wait_run(10, n);
      check(st & 8'hfc, 8'h7c);
      $display("reset pin test done");
   endtask

   task automatic t_masked();
      int n;
      @(posedge core_clk) mask_req <= 1'b0;
      enter(SEL_DEEP_IDLE);
      hit(7'h04);
      repeat (3) @(posedge core_clk);
      #1;
      check(st & 8'hfc, 8'hbc);
      @(posedge core_clk) mask_req <= 1'b1;
      hit(7'h04);
      wait_run(10, n);
      check(st & 8'hfc, 8'h7c);
      $display("masked pin test done");
   endtask

   initial begin
      rst         = 1'b1;
      reset_pin_n = 1'b1;
      idle_req    = 1'b0;
      mask_req    = 1'b1;
      sel_req     = 2'h0;
      stim        = 7'h00;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      t_modes();
      try_wake(SEL_HALT, 7'h59, 7'h20, 3200);
      try_wake(SEL_DEEP_IDLE, 7'h50, 7'h20, 10);
      try_wake(SEL_STANDBY, 7'h50, 7'h08, 1100);
      try_wake(SEL_DEEP_IDLE, 7'h40, 7'h01, 10);
      try_wake(SEL_STANDBY, 7'h40, 7'h01, 1100);
      try_wake(SEL_LIGHT_IDLE, 7'h40, 7'h10, 10);
      t_reset_pin();
      t_masked();
      end_of_test();
   end
endmodule
